// ==== rtl/cfp_pkg.sv ====
// Purpose: shared constants for the fetch and pipeline control core
// Assumes: 16-bit instruction words, 21-bit byte program counter
// Notes: opcode patterns cover only the control-flow, table and two-word subset handled here
package cfp_pkg;
  localparam int PC_W = 21;
  localparam int IW = 16;
  localparam int DW = 8;
  localparam int DA_W = 12;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [1:0] PH_ONE = 2'h0;
  localparam logic [1:0] PH_TWO = 2'h1;
  localparam logic [1:0] PH_THREE = 2'h2;
  localparam logic [1:0] PH_FOUR = 2'h3;
  localparam logic [IW-1:0] NOP_WORD = 16'h0000;
  // opcode patterns matched on the top bits of the word
  localparam logic [3:0] OP_SECOND = 4'hf;
  localparam logic [3:0] OP_MOVE_FF = 4'hc;
  localparam logic [7:0] OP_JUMP = 8'hef;
  localparam logic [6:0] OP_CALL = 7'h76;
  localparam logic [9:0] OP_FSR_LOAD = 10'h3b8;
  localparam logic [7:0] OP_RET_LIT = 8'h0c;
  localparam logic [15:0] OP_RETURN = 16'h0012;
  localparam logic [4:0] OP_BRA = 5'h1a;
  localparam logic [4:0] OP_RCALL = 5'h1b;
  // add w to file with d=1, a=0 and file 0xf9 (low byte of the counter)
  localparam logic [5:0] OP_ADD_W_TO_FILE = 6'h09;
  localparam logic [7:0] PCL_ADDR = 8'hf9;
  localparam logic [3:0] OP_TABLE = 4'h0;
  localparam logic [5:0] TBL_RD_LO = 6'h02;
  localparam int STK_W = 5;
  localparam int STK_DEPTH = 31;
endpackage : cfp_pkg

// ==== rtl/cfp_phase_gen.sv ====
// Purpose: divide the core clock by four into one-hot phase strobes
// Assumes: synchronous active-high reset
// Notes: strobes never overlap since they decode one counter
module cfp_phase_gen (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // phase strobes
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four
);
  logic [1:0] count;

  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= cfp_pkg::PH_ONE;
    end else begin
      count <= count + 2'h1;
    end
  end

  assign phase_one = (count == cfp_pkg::PH_ONE);
  assign phase_two = (count == cfp_pkg::PH_TWO);
  assign phase_three = (count == cfp_pkg::PH_THREE);
  assign phase_four = (count == cfp_pkg::PH_FOUR);
endmodule : cfp_phase_gen

// ==== rtl/cfp_stack_mem.sv ====
// Purpose: return address storage for calls
// Assumes: one write and one read per cycle
// Notes: read data come out of a register
module cfp_stack_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int WIDTH = 21
) (
  // clock
  input wire logic mclk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : cfp_stack_mem

// ==== rtl/cfp_fetch_core.sv ====
// Purpose: instruction fetch and pipeline control of the 8-bit core
// Assumes: program memory answers within the same instruction cycle
// Notes: only control-flow, table and two-word opcodes are decoded here
// Operation
// - The core clock is divided by four into four non-overlapping phases.
// - The counter steps on phase one and the fetched word latches in four.
// - The prior fetched word enters the instruction register in phase one.
// - Operand reads happen in phase two and destination writes in four.
// - Fetch overlaps execute so plain instructions retire one per cycle.
// - A counter change costs two cycles and discards the fetched word.
// - Program memory is byte addressed with words at even addresses.
// - The counter steps by two and its lowest bit always reads zero.
// - Absolute jump and call load the word address into bits 20 to 1.
// - Relative branch offsets count words, so bytes move by twice that.
// - Second words of two-word instructions carry ones in the top nibble.
// - A lone second word is a no-op, but after its first word it is used.
// - Adding the working register to the low byte moves the counter.
// - Return with literal loads the working register and returns.
// - Table reads use the pointer as a byte address, one byte each.
// - A call bumps the stack pointer then stores the next address.
module cfp_fetch_core #(
  parameter int PC_W = cfp_pkg::PC_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // program memory
  output logic [PC_W-1:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [15:0] pmem_rdata,
  // data memory
  output logic [11:0] dmem_addr,
  output logic dmem_rd,
  input wire logic [7:0] dmem_rdata,
  output logic dmem_wr,
  output logic [7:0] dmem_wdata,
  // table access
  input wire logic [PC_W-1:0] table_pointer,
  output logic [7:0] table_latch,
  // observation
  output logic [PC_W-1:0] program_counter,
  output logic [15:0] instruction_register,
  output logic [7:0] working_register,
  output logic [4:0] return_stack_pointer,
  output logic phase_one,
  output logic phase_two,
  output logic phase_three,
  output logic phase_four,
  output logic flushed
);
  logic [15:0] fetch_word;
  logic [15:0] prev_word;
  logic flush_pending;
  logic exec_flush;
  logic [PC_W-1:0] pc_target;
  logic pc_load;
  logic [PC_W-1:0] stack_rdata;
  logic stack_wr;
  logic [4:0] stack_wr_addr;
  logic [4:0] next_sp;
  logic table_pending;
  // a stolen fetch slot holds the counter and idles the next execute slot
  logic table_hold;
  logic [7:0] operand;

  cfp_phase_gen u_phase (
    .mclk(mclk),
    .rst(rst),
    .phase_one(phase_one),
    .phase_two(phase_two),
    .phase_three(phase_three),
    .phase_four(phase_four)
  );

  cfp_stack_mem #(.DEPTH(32), .AW(5), .WIDTH(PC_W)) u_stack (
    .mclk(mclk),
    .wr_en(stack_wr),
    .wr_addr(stack_wr_addr),
    .wr_data(program_counter),
    .rd_addr(return_stack_pointer),
    .rd_data(stack_rdata)
  );

  // sign-extend a word offset and double it into a byte offset
  function automatic logic [PC_W-1:0] word_off(input logic [10:0] off);
    word_off = {{(PC_W-12){off[10]}}, off, 1'b0};
  endfunction : word_off

  // decode of the executing word
  wire [15:0] ir = instruction_register;
  wire is_second = (ir[15:12] == cfp_pkg::OP_SECOND);
  wire is_jump = (ir[15:8] == cfp_pkg::OP_JUMP);
  wire is_call = (ir[15:9] == cfp_pkg::OP_CALL);
  wire is_moveff = (ir[15:12] == cfp_pkg::OP_MOVE_FF);
  wire is_fsrload = (ir[15:6] == cfp_pkg::OP_FSR_LOAD);
  wire is_two_word = is_jump | is_call | is_moveff | is_fsrload;
  wire is_retlit = (ir[15:8] == cfp_pkg::OP_RET_LIT);
  wire is_return = (ir == cfp_pkg::OP_RETURN);
  wire is_bra = (ir[15:11] == cfp_pkg::OP_BRA);
  wire is_rcall = (ir[15:11] == cfp_pkg::OP_RCALL);
  wire is_addpcl = (ir[15:10] == cfp_pkg::OP_ADD_W_TO_FILE) && ir[9] && !ir[8]
    && (ir[7:0] == cfp_pkg::PCL_ADDR);
  wire is_table = (ir[15:4] == 12'h000) && (ir[3:0] >= 4'h8)
    && (ir[3:0] <= 4'hb);

  // the first word of a pair waits in prev_word while its second executes
  wire second_used = is_second && (prev_word != cfp_pkg::NOP_WORD);
  wire [15:0] first = prev_word;
  wire f_jump = (first[15:8] == cfp_pkg::OP_JUMP);
  wire f_call = (first[15:9] == cfp_pkg::OP_CALL);
  wire f_moveff = (first[15:12] == cfp_pkg::OP_MOVE_FF);
  wire [PC_W-1:0] abs_target = {ir[11:0], first[7:0], 1'b0};

  wire live = !exec_flush;

  always_comb begin
    pc_load = 1'b0;
    pc_target = program_counter;
    if (live) begin
      if (second_used && (f_jump || f_call)) begin
        pc_load = 1'b1;
        // counter steps once more before the target word is fetched
        pc_target = abs_target - cfp_pkg::PC_STEP;
      end else if (is_bra || is_rcall) begin
        pc_load = 1'b1;
        pc_target = program_counter - cfp_pkg::PC_STEP
          + word_off(ir[10:0]);
      end else if (is_addpcl) begin
        pc_load = 1'b1;
        // counter already points past the add; software keeps it even
        pc_target = program_counter - cfp_pkg::PC_STEP
          + {{(PC_W-8){1'b0}}, working_register};
      end else if (is_retlit || is_return) begin
        pc_load = 1'b1;
        pc_target = stack_rdata - cfp_pkg::PC_STEP;
      end
    end
  end

  // pushes happen for rcall and for the second word of an absolute call
  wire do_push = live && phase_two && (is_rcall || (second_used && f_call));
  wire do_pop = live && phase_four && (is_retlit || is_return);
  assign next_sp = do_push ? return_stack_pointer + 5'h01 :
    do_pop ? return_stack_pointer - 5'h01 : return_stack_pointer;
  assign stack_wr = live && phase_three
    && (is_rcall || (second_used && f_call));
  assign stack_wr_addr = return_stack_pointer;

  // data memory strobes; a flushed slot or stray second word touches nothing
  assign dmem_rd = live && phase_two && is_moveff;
  assign dmem_wr = live && phase_four && second_used && f_moveff;
  // source sits in the first word, destination in the second
  assign dmem_addr = ir[11:0];
  assign dmem_wdata = operand;

  // instruction fetch: pointer in phase one, word latched in phase four
  assign pmem_addr = table_pending ? table_pointer : program_counter;
  assign pmem_rd = phase_four;

  always_ff @(posedge mclk) begin
    if (rst) begin
      program_counter <= cfp_pkg::PC_RESET;
    end else if (phase_one && !table_hold) begin
      program_counter <= program_counter + cfp_pkg::PC_STEP;
    end else if (phase_four && pc_load) begin
      program_counter <= {pc_target[PC_W-1:1], 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fetch_word <= cfp_pkg::NOP_WORD;
    end else if (phase_four && !table_pending) begin
      fetch_word <= pmem_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flush_pending <= 1'b0;
    end else if (phase_four) begin
      flush_pending <= pc_load;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      instruction_register <= cfp_pkg::NOP_WORD;
      exec_flush <= 1'b0;
      prev_word <= cfp_pkg::NOP_WORD;
    end else if (phase_one) begin
      // keep the prior word so a second word can find its first
      prev_word <= (is_two_word && live) ? instruction_register
        : cfp_pkg::NOP_WORD;
      instruction_register <= (flush_pending || table_hold)
        ? cfp_pkg::NOP_WORD : fetch_word;
      exec_flush <= flush_pending;
    end
  end
  assign flushed = exec_flush;

  always_ff @(posedge mclk) begin
    if (rst) begin
      return_stack_pointer <= 5'h00;
    end else begin
      return_stack_pointer <= next_sp;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      operand <= 8'h00;
    end else if (dmem_rd) begin
      operand <= dmem_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      working_register <= 8'h00;
    end else if (live && phase_four && is_retlit) begin
      working_register <= ir[7:0];
    end
  end

  // a table read borrows the next phase-four fetch slot for one byte
  always_ff @(posedge mclk) begin
    if (rst) begin
      table_pending <= 1'b0;
    end else if (phase_two) begin
      table_pending <= live && is_table;
    end else if (phase_four) begin
      table_pending <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      table_hold <= 1'b0;
    end else if (phase_four) begin
      table_hold <= table_pending;
    end else if (phase_one) begin
      table_hold <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      table_latch <= 8'h00;
    end else if (phase_four && table_pending) begin
      table_latch <= table_pointer[0] ? pmem_rdata[15:8]
        : pmem_rdata[7:0];
    end
  end
endmodule : cfp_fetch_core

// ==== dv/cfp_fetch_core_properties.sv ====
// Purpose: port timing checks for the fetch and pipeline core
// Assumes: one clock, synchronous active-high reset
// Notes: a table slot may hold the counter for one step
module cfp_fetch_core_properties #(
  parameter int PC_W = 21
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // observed ports
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [15:0] instruction_register,
  input wire logic pmem_rd,
  input wire logic dmem_rd,
  input wire logic dmem_wr,
  input wire logic phase_one,
  input wire logic phase_two,
  input wire logic phase_three,
  input wire logic phase_four,
  input wire logic flushed
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_phase_ring: assert property (phase_one |=> phase_two ##1 phase_three
    ##1 phase_four ##1 phase_one) else $error("phase sequence broken");
  a_phase_single: assert property ($onehot({phase_one, phase_two,
    phase_three, phase_four})) else $error("phases overlap");
  a_pc_even: assert property (program_counter[0] == 1'b0)
    else $error("counter lowest bit set");
  a_pc_step: assert property (phase_one |=>
    program_counter - $past(program_counter) inside {21'h0, 21'h2})
    else $error("counter step not two");
  a_pc_quiet: assert property (phase_two || phase_three |=>
    $stable(program_counter)) else $error("counter moved mid cycle");
  a_ir_load: assert property (!phase_one |=>
    $stable(instruction_register)) else $error("ir loaded off phase one");
  a_fetch_slot: assert property (pmem_rd |-> phase_four)
    else $error("fetch outside phase four");
  a_read_slot: assert property (dmem_rd |-> phase_two)
    else $error("operand read outside phase two");
  a_write_slot: assert property (dmem_wr |-> phase_four)
    else $error("write outside phase four");
  a_flush_quiet: assert property (flushed && phase_three |->
    instruction_register == 16'h0000 && !dmem_rd && !dmem_wr)
    else $error("flushed slot not a quiet nop");
endmodule : cfp_fetch_core_properties

bind cfp_fetch_core cfp_fetch_core_properties #(.PC_W(PC_W)) chk_inst (
  .mclk(mclk), .rst(rst), .program_counter(program_counter),
  .instruction_register(instruction_register), .pmem_rd(pmem_rd),
  .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .phase_one(phase_one),
  .phase_two(phase_two), .phase_three(phase_three),
  .phase_four(phase_four), .flushed(flushed));

// ==== dv/cfp_pmem_model.sv ====
// Purpose: program memory answering each fetch in the same cycle
// Assumes: 256 words, low byte at the even address
// Notes: idle data is inverted so a stale word never passes
module cfp_pmem_model #(
  parameter int PC_W = 21
) (
  // fetch side
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [15:0] pmem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:255];
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // word index drops the byte bit
  assign pmem_rdata = pmem_rd ? mem[pmem_addr[8:1]] : ~mem[pmem_addr[8:1]];
endmodule : cfp_pmem_model

// ==== dv/test_cpu_fetch_pipeline.sv ====
// Purpose: self-checking bench for the fetch and pipeline core
// Assumes: 10 MHz clock, inputs driven on the falling edge
// Notes: one looping program exercises call, table, move and branch
module test_cpu_fetch_pipeline;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst, pmem_rd, dmem_rd, dmem_wr, flushed, lone_wr;
  logic phase_one, phase_two, phase_three, phase_four;
  logic [20:0] pmem_addr, table_pointer, program_counter;
  logic [15:0] pmem_rdata, instruction_register;
  logic [11:0] dmem_addr, wr_addr;
  logic [7:0] dmem_rdata, dmem_wdata, table_latch, working_register, wr_data;
  logic [4:0] return_stack_pointer, sp_max;
  logic [20:0] trace [$];
  int bad_count, compares, nflush;
  cfp_fetch_core cfp_fetch_core_inst (.mclk(mclk), .rst(rst),
    .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata),
    .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata),
    .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata),
    .table_pointer(table_pointer), .table_latch(table_latch),
    .program_counter(program_counter),
    .instruction_register(instruction_register),
    .working_register(working_register),
    .return_stack_pointer(return_stack_pointer), .phase_one(phase_one),
    .phase_two(phase_two), .phase_three(phase_three),
    .phase_four(phase_four), .flushed(flushed));
  cfp_pmem_model cfp_pmem_model_inst (.pmem_addr(pmem_addr),
    .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata));
  always @(posedge mclk) begin
    if (rst === 1'b0 && pmem_rd === 1'b1) trace.push_back(pmem_addr);
    if (rst === 1'b0 && dmem_wr === 1'b1)
      {wr_addr, wr_data} <= {dmem_addr, dmem_wdata};
    if (dmem_wr === 1'b1 && dmem_addr === 12'h999) lone_wr <= 1'b1;
    if (flushed === 1'b1 && phase_one === 1'b1) nflush++;
    if (rst === 1'b0 && return_stack_pointer > sp_max)
      sp_max <= return_stack_pointer;
  end
  task automatic check(string name, logic [20:0] exp, logic [20:0] got);
    compares++;
    if (exp !== got) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wrap_up;
    $display("bad_count=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic t_reset;
    #1;
    check("first phase", 21'h1, {20'h0, phase_one});
    check("reset counter", 21'h0, program_counter);
    check("reset ir", 21'h0, {5'h0, instruction_register});
    repeat (4) @(negedge mclk);
    check("phase again", 21'h1, {20'h0, phase_one});
    check("counter step", 21'h2, program_counter);
  endtask : t_reset
  task automatic t_call_return;
    int p;
    p = -1;
    repeat (400) @(negedge mclk);
    foreach (trace[i]) if (p < 0 && trace[i] === 21'h20) p = i;
    if (p < 2) p = 2;
    check("call second word", 21'h6, trace[p-2]);
    check("discarded fetch", 21'h8, trace[p-1]);
    check("return target", 21'h8, trace[p+2]);
    check("literal", 21'h5a, {13'h0, working_register});
    check("stack depth", 21'h1, {16'h0, sp_max});
    check("stack back", 21'h0, {16'h0, return_stack_pointer});
    check("flushes seen", 21'h1, {20'h0, nflush > 0});
  endtask : t_call_return
  task automatic t_move_table;
    int q;
    q = -1;
    foreach (trace[i]) if (q < 0 && trace[i] === 21'h10) q = i;
    if (q < 0) q = 0;
    check("table byte", 21'ha5, {13'h0, table_latch});
    check("move dest", 21'h456, {9'h0, wr_addr});
    check("move data", 21'h3c, {13'h0, wr_data});
    check("lone word quiet", 21'h0, {20'h0, lone_wr});
    check("branch target", 21'h0, trace[q+2]);
  endtask : t_move_table
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    table_pointer = 21'h000041;
    dmem_rdata = 8'h3c;
    lone_wr = 1'b0;
    sp_max = 5'h00;
    repeat (8) @(negedge mclk);
    // call 0x20, table read, move 123 to 456, lone word, branch to 0
    foreach (cfp_pmem_model_inst.mem[i]) begin
      case (i)
        2: cfp_pmem_model_inst.mem[i] = 16'hec10;
        3: cfp_pmem_model_inst.mem[i] = 16'hf000;
        4: cfp_pmem_model_inst.mem[i] = 16'h0008;
        5: cfp_pmem_model_inst.mem[i] = 16'hc123;
        6: cfp_pmem_model_inst.mem[i] = 16'hf456;
        7: cfp_pmem_model_inst.mem[i] = 16'hf999;
        8: cfp_pmem_model_inst.mem[i] = 16'hd7f7;
        16: cfp_pmem_model_inst.mem[i] = 16'h0c5a;
        32: cfp_pmem_model_inst.mem[i] = 16'ha55a;
        default: cfp_pmem_model_inst.mem[i] = 16'h0000;
      endcase
    end
    rst = 1'b0;
    t_reset;
    t_call_return;
    t_move_table;
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    wrap_up;
  end
endmodule : test_cpu_fetch_pipeline
